// File: logic/eth_tx_client.sv
// Transmit client path: byte stream in, PHY byte interface out, statistics and sideband.
module eth_tx_client #(
  parameter int unsigned MAX_DEFER_CYCLES = 8192
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [7:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK,
  input  wire logic [7:0]  TX_TDATA,
  input  wire logic        TX_TVALID,
  input  wire logic        TX_TLAST,
  input  wire logic        TX_TUSER,
  output logic             TX_TREADY,
  input  wire logic [7:0]  TX_IFG_DELAY,
  output logic             TX_COLLISION,
  output logic             TX_RETRANSMIT,
  output logic      [32:0] TX_STATS,
  output logic             TX_STATS_VALID,
  input  wire logic        PAUSE_REQ,
  input  wire logic        PFC_REQ,
  output logic      [7:0]  PHY_TXD,
  output logic             PHY_TX_EN,
  output logic             PHY_TX_ER,
  input  wire logic        PHY_COL,
  input  wire logic        PHY_CRS,
  input  wire logic [7:0]  PHY_RXD,
  input  wire logic        PHY_RX_DV,
  input  wire logic        PHY_RX_ER,
  output logic      [7:0]  RX_TDATA,
  output logic             RX_TVALID,
  output logic             RX_TUSER
);
  localparam logic [15:0] DEFER_LAST = 16'(MAX_DEFER_CYCLES - 1);

  eth_tx_pkg::core_state_t s;
  eth_tx_pkg::core_state_t next_s;
  eth_tx_pkg::phy_byte_t   din;
  eth_tx_pkg::phy_byte_t   tx_out;
  eth_tx_pkg::phy_byte_t   rx_out;
  logic                    strobe;
  logic                    acc;
  logic                    half;
  logic                    gig;
  logic                    req;
  logic [7:0]              gap_len;
  logic [4:0]              tx_tap;
  logic [4:0]              gig_run;

  // Decoded control and handshake terms.
  assign strobe  = (s.div == 7'h00);
  assign half    = s.ctrl[eth_tx_pkg::CTRL_HALF];
  assign gig     = (s.ctrl[eth_tx_pkg::CTRL_SPD +: 2] == eth_tx_pkg::SPEED_1G);
  assign req     = WB_CYC && WB_STB;
  assign tx_tap  = gig ? eth_tx_pkg::TX_LAT_FAST : eth_tx_pkg::TX_LAT_SLOW;
  // Ready only on the byte strobe while sending (always high in S_DROP), so slow speeds meter the client.
  assign TX_TREADY = ((s.fsm == eth_tx_pkg::S_SEND) && strobe) || (s.fsm == eth_tx_pkg::S_DROP);
  assign acc     = (s.fsm == eth_tx_pkg::S_SEND) && strobe && TX_TVALID;
  // The client gap only widens the minimum, never shortens it.
  assign gap_len = (s.ctrl[eth_tx_pkg::CTRL_IFG] && (TX_IFG_DELAY > eth_tx_pkg::MIN_IFG)) ?
                   TX_IFG_DELAY : eth_tx_pkg::MIN_IFG;

  // Pause and priority pause frame contents by byte index.
  function automatic logic [7:0] ctrl_byte(input logic [5:0] idx, input logic pfc);
    logic [15:0] opc;
    opc = pfc ? eth_tx_pkg::OPC_PFC : eth_tx_pkg::OPC_PAUSE;
    if (idx < 6'h06) begin
      ctrl_byte = eth_tx_pkg::CTRL_DA[8'(6'h2f - {idx, 3'h0}) -: 8];
    end else if (idx == 6'h0c) begin
      ctrl_byte = eth_tx_pkg::TYPE_CTRL[15:8];
    end else if (idx == 6'h0d) begin
      ctrl_byte = eth_tx_pkg::TYPE_CTRL[7:0];
    end else if (idx == 6'h0e) begin
      ctrl_byte = opc[15:8];
    end else if (idx == 6'h0f) begin
      ctrl_byte = opc[7:0];
    end else if (idx == 6'h10 || idx == 6'h11) begin
      ctrl_byte = 8'hff;
    end else begin
      ctrl_byte = 8'h00;
    end
  endfunction

  // Records one outgoing byte into the per-frame flags.
  function automatic eth_tx_pkg::core_state_t rec(input eth_tx_pkg::core_state_t v,
                                                  input eth_tx_pkg::phy_byte_t b, input logic vlan_en);
    rec = v;
    if (v.cnt == 14'h0000) begin
      rec.mcast = b.data[0];
      rec.bcast = (b.data == 8'hff);
    end else if (v.cnt < 14'h0006) begin
      rec.bcast = v.bcast && (b.data == 8'hff);
    end else if (v.cnt == 14'h000c) begin
      rec.type_hi = b.data;
    end else if (v.cnt == 14'h000d) begin
      rec.is_ctrl = ({v.type_hi, b.data} == eth_tx_pkg::TYPE_CTRL);
      rec.is_vlan = vlan_en && ({v.type_hi, b.data} == eth_tx_pkg::TYPE_VLAN);
    end
    rec.underrun = v.underrun || b.er;
    if (v.cnt != eth_tx_pkg::LEN_SAT) begin
      rec.cnt = v.cnt + 14'h0001;
    end
  endfunction

  // Assembles the per-frame statistics; bit 30 is overlaid live at the port.
  function automatic logic [32:0] mk_stats(input eth_tx_pkg::core_state_t v, input logic late,
                                           input logic exc, input logic pause, input logic pfc);
    mk_stats = '0;
    mk_stats[eth_tx_pkg::SB_PFC] = pfc;
    mk_stats[eth_tx_pkg::SB_PAUSE] = pause;
    mk_stats[eth_tx_pkg::SB_ATT_LO +: 4] = v.tries;
    mk_stats[eth_tx_pkg::SB_EXCOL] = exc;
    mk_stats[eth_tx_pkg::SB_LATE] = late;
    mk_stats[eth_tx_pkg::SB_OVERLONG] = v.overlong_wait_bit;
    mk_stats[eth_tx_pkg::SB_DEFER] = v.deferred;
    mk_stats[eth_tx_pkg::SB_VLAN] = v.is_vlan;
    mk_stats[eth_tx_pkg::SB_LEN_LO +: 14] = v.cnt;
    mk_stats[eth_tx_pkg::SB_CTRL] = v.is_ctrl;
    mk_stats[eth_tx_pkg::SB_UNDERRUN] = v.underrun;
    mk_stats[eth_tx_pkg::SB_MCAST] = v.mcast;
    mk_stats[eth_tx_pkg::SB_BCAST] = v.bcast;
    mk_stats[eth_tx_pkg::SB_OK] = !(v.underrun || late || exc);
  endfunction

  // Next-state logic for the whole block: pins, bus, frame engine.
  always_comb begin
    next_s = s;
    din = '0;
    next_s.stats_valid = 1'b0;
    next_s.collision = 1'b0;
    next_s.retransmit = 1'b0;
    // Pin synchronisers; only the second stages are read below.
    next_s.col_m = PHY_COL;
    next_s.col = s.col_m;
    next_s.crs_m = PHY_CRS;
    next_s.crs = s.crs_m;
    next_s.rx_m = '{en: PHY_RX_DV, er: PHY_RX_ER, data: PHY_RXD};
    next_s.rx_s = s.rx_m;
    // Byte strobe divider chosen by speed.
    if (strobe) begin
      unique case (s.ctrl[eth_tx_pkg::CTRL_SPD +: 2])
        eth_tx_pkg::SPEED_100: next_s.div = eth_tx_pkg::DIV_100_M1;
        eth_tx_pkg::SPEED_10:  next_s.div = eth_tx_pkg::DIV_10_M1;
        default:               next_s.div = eth_tx_pkg::DIV_1G_M1;
      endcase
    end else begin
      next_s.div = s.div - 7'h01;
    end
    // Wishbone slave: one wait state, ack for one cycle, write at the ack edge.
    next_s.wb_ack = req && !s.wb_ack;
    if (req && !s.wb_ack) begin
      unique case (WB_ADR)
        eth_tx_pkg::ADDR_CTRL:   next_s.wb_dat = {26'h0000000, s.ctrl};
        eth_tx_pkg::ADDR_STATUS: next_s.wb_dat = {20'h00000, s.pfc_pend, s.pause_pend, s.tries, 1'b0, s.fsm};
        eth_tx_pkg::ADDR_STATS:  next_s.wb_dat = s.stats[31:0];
        default:                 next_s.wb_dat = 32'h00000000;
      endcase
    end
    if (req && s.wb_ack && WB_WE && (WB_ADR == eth_tx_pkg::ADDR_CTRL) && WB_SEL[0]) begin
      next_s.ctrl = WB_DAT_I[5:0];
    end
    // Frame engine.
    unique case (s.fsm)
      eth_tx_pkg::S_IDLE: begin
        if (s.pause_pend || s.pfc_pend || TX_TVALID) begin
          next_s.fsm = eth_tx_pkg::S_GAP;
          next_s.gap = gap_len;
          next_s.tries = 4'h0;
          next_s.deferred = 1'b0;
          next_s.overlong_wait_bit = 1'b0;
          next_s.wait_cnt = 16'h0000;
        end
      end
      eth_tx_pkg::S_GAP: begin
        // Carrier holds the gap open in half duplex; that is a deferral.
        if (half && s.crs) begin
          next_s.deferred = 1'b1;
          next_s.gap = gap_len;
          if (s.wait_cnt == DEFER_LAST) begin
            next_s.overlong_wait_bit = 1'b1;
          end else begin
            next_s.wait_cnt = s.wait_cnt + 16'h0001;
          end
        end else if (strobe) begin
          next_s.cnt = 14'h0000;
          next_s.underrun = 1'b0;
          next_s.mcast = 1'b0;
          next_s.bcast = 1'b0;
          next_s.is_ctrl = 1'b0;
          next_s.is_vlan = 1'b0;
          next_s.cidx = 6'h00;
          if (s.gap != 8'h00) begin
            next_s.gap = s.gap - 8'h01;
          end else if (s.pause_pend || s.pfc_pend) begin
            next_s.fsm = eth_tx_pkg::S_CTRL;
            next_s.ctrl_pfc = s.pfc_pend;
          end else if (TX_TVALID) begin
            next_s.fsm = eth_tx_pkg::S_SEND;
          end else begin
            next_s.fsm = eth_tx_pkg::S_IDLE;
          end
        end
      end
      eth_tx_pkg::S_SEND: begin
        if (acc) begin
          din = '{en: 1'b1, er: TX_TUSER, data: TX_TDATA};
          if (half && s.col) begin
            din.er = 1'b1;
            next_s = rec(next_s, din, s.ctrl[eth_tx_pkg::CTRL_VLAN]);
            next_s.collision = 1'b1;
            if ((s.cnt >= eth_tx_pkg::SLOT_BYTES) || (s.tries == 4'hf)) begin
              // Late or sixteenth collision: give up and report.
              next_s.stats = mk_stats(next_s, s.cnt >= eth_tx_pkg::SLOT_BYTES,
                                      s.cnt < eth_tx_pkg::SLOT_BYTES, 1'b0, 1'b0);
              next_s.stats_valid = 1'b1;
              next_s.fsm = TX_TLAST ? eth_tx_pkg::S_IDLE : eth_tx_pkg::S_DROP;
            end else begin
              next_s.retransmit = 1'b1;
              next_s.tries = s.tries + 4'h1;
              next_s.gap = gap_len;
              next_s.fsm = eth_tx_pkg::S_GAP;
            end
          end else begin
            next_s = rec(next_s, din, s.ctrl[eth_tx_pkg::CTRL_VLAN]);
            if (TX_TLAST) begin
              next_s.stats = mk_stats(next_s, 1'b0, 1'b0, 1'b0, 1'b0);
              next_s.stats_valid = 1'b1;
              next_s.fsm = eth_tx_pkg::S_IDLE;
            end
          end
        end
      end
      eth_tx_pkg::S_CTRL: begin
        if (strobe) begin
          din = '{en: 1'b1, er: 1'b0, data: ctrl_byte(s.cidx, s.ctrl_pfc)};
          next_s = rec(next_s, din, s.ctrl[eth_tx_pkg::CTRL_VLAN]);
          next_s.cidx = s.cidx + 6'h01;
          if (s.cidx == eth_tx_pkg::CTRL_LAST) begin
            next_s.stats = mk_stats(next_s, 1'b0, 1'b0, !s.ctrl_pfc, s.ctrl_pfc);
            next_s.stats_valid = 1'b1;
            next_s.pause_pend = 1'b0;
            next_s.pfc_pend = 1'b0;
            next_s.fsm = eth_tx_pkg::S_IDLE;
          end
        end
      end
      eth_tx_pkg::S_DROP: begin
        // Swallow the rest of an abandoned frame so it never starts a new one.
        if (TX_TVALID && TX_TLAST) begin
          next_s.fsm = eth_tx_pkg::S_IDLE;
        end
      end
      default: begin
        next_s.fsm = eth_tx_pkg::S_IDLE;
      end
    endcase
    // Requests are latched last so a new one wins over the clear.
    if (PAUSE_REQ && !s.ctrl[eth_tx_pkg::CTRL_PFC]) begin
      next_s.pause_pend = 1'b1;
    end
    if (PFC_REQ && s.ctrl[eth_tx_pkg::CTRL_PFC]) begin
      next_s.pfc_pend = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s <= '{fsm: eth_tx_pkg::S_IDLE, ctrl: eth_tx_pkg::CTRL_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Transmit pipeline sets the client-to-PHY latency.
  byte_delay_line #(
    .W     ($bits(eth_tx_pkg::phy_byte_t)),
    .DEPTH (eth_tx_pkg::TX_DEPTH)
  ) u_tx_pipe (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .en    (strobe),
    .tap   (tx_tap),
    .din   (din),
    .dout  (tx_out)
  );

  // Receive pipeline; the synchroniser supplies two cycles of the total.
  byte_delay_line #(
    .W     ($bits(eth_tx_pkg::phy_byte_t)),
    .DEPTH (eth_tx_pkg::RX_DEPTH)
  ) u_rx_pipe (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .en    (strobe),
    .tap   (eth_tx_pkg::RX_TAP),
    .din   (s.rx_s),
    .dout  (rx_out)
  );

  // Outputs; in full duplex the collision sideband stays low.
  assign PHY_TXD        = tx_out.data;
  assign PHY_TX_EN      = tx_out.en;
  assign PHY_TX_ER      = tx_out.er;
  assign RX_TDATA       = rx_out.data;
  assign RX_TVALID      = rx_out.en;
  assign RX_TUSER       = rx_out.er;
  assign TX_COLLISION   = s.collision && half;
  assign TX_RETRANSMIT  = s.retransmit && half;
  assign TX_STATS_VALID = s.stats_valid;
  assign TX_STATS       = {s.stats[32] && s.ctrl[eth_tx_pkg::CTRL_PFC], s.stats[31], tx_out.en,
                           s.stats[29:0]};
  assign WB_DAT_O       = s.wb_dat;
  assign WB_ACK         = s.wb_ack;

  // Consecutive gigabit cycles, saturating; latency checks skip any window that spans a speed change.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gig_run <= 5'h00;
    end else if (!gig) begin
      gig_run <= 5'h00;
    end else if (gig_run != 5'h1f) begin
      gig_run <= gig_run + 5'h01;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  AST_TX_LATENCY: assert property (gig && gig_run >= 5'h08 && acc
                                   |-> ##8 (gig_run < 5'h10 || (PHY_TX_EN && PHY_TXD == $past(TX_TDATA, 8))))
    else $error("Transmit byte did not reach the PHY after eight cycles.");
  AST_RX_LATENCY: assert property (gig && gig_run >= 5'h0f && PHY_RX_DV
                                   |-> ##15 (gig_run < 5'h1e || (RX_TVALID && RX_TDATA == $past(PHY_RXD, 15))))
    else $error("Receive byte did not reach the client after fifteen cycles.");
  AST_UNDERRUN_ER: assert property (gig && gig_run >= 5'h08 && acc && TX_TUSER
                                    |-> ##8 (gig_run < 5'h10 || PHY_TX_ER))
    else $error("Client error flag not passed to the PHY.");
  AST_READY_PACE: assert property (!gig && TX_TREADY && s.fsm == eth_tx_pkg::S_SEND
                                   |=> !TX_TREADY [*8])
    else $error("Ready not paced at slow speed.");
  AST_FULL_DUPLEX: assert property (!half |-> !TX_COLLISION && !TX_RETRANSMIT)
    else $error("Collision sideband active in full duplex.");
  AST_RETX_WITH_COL: assert property (TX_RETRANSMIT |-> TX_COLLISION && $past(s.col))
    else $error("Retransmit without a collision.");
  AST_STATS_PULSE: assert property (TX_STATS_VALID |=> !TX_STATS_VALID)
    else $error("Statistics strobe longer than one cycle.");
  AST_PFC_BIT: assert property (!s.ctrl[eth_tx_pkg::CTRL_PFC] |-> !TX_STATS[32])
    else $error("Bit 32 set without priority flow control.");
  AST_RESERVED: assert property (!TX_STATS[29] && !TX_STATS[24])
    else $error("Reserved statistics bits not zero.");
  AST_EXCESSIVE: assert property (TX_STATS_VALID && TX_STATS[23] |-> TX_STATS[28:25] == 4'hf && !TX_STATS[0])
    else $error("Excessive collision without sixteen attempts.");
  AST_LEN_SAT: assert property (TX_STATS_VALID |-> TX_STATS[18:5] <= eth_tx_pkg::LEN_SAT)
    else $error("Frame length above saturation value.");
  AST_PAUSE_LEN: assert property (TX_STATS_VALID && TX_STATS[31] |-> TX_STATS[4] && TX_STATS[18:5] == 14'h003c)
    else $error("Pause frame statistics wrong.");

  COV_FRAME: cover property (acc && TX_TLAST ##1 TX_STATS_VALID && TX_STATS[0]);
  COV_RETX: cover property (TX_COLLISION && TX_RETRANSMIT);
  COV_PAUSE: cover property (TX_STATS_VALID && TX_STATS[31]);
endmodule // eth_tx_client

// File: logic/eth_tx_pkg.sv
// Constants, types and carrier structs for the transmit client path.
// Functional notes
// - A client byte reaches the PHY transmit outputs 8 enabled cycles later, 7 when slow.
// - A PHY receive byte reaches the client receive port 15 cycles later at gigabit; at 10/100 it takes 2 cycles plus 13 enabled cycles.
// - Client user flag marks a bad frame; device drives the PHY error with it.
// - Ready shows a byte taken with valid high; it paces bytes at 10/100.
// - Half duplex reports medium collisions during client frames on the collision output; full duplex holds zero.
// - Retransmit with collision asks for the frame again; full duplex holds retransmit zero.
// - A one-cycle statistics strobe follows each frame and qualifies the vector.
// - With priority flow control the statistics vector gains a top bit 32.
// - Bit 32 marks a priority flow control frame that the device generated and sent.
// - Bit 31 marks a pause frame sent in answer to the pause request.
// - Bit 30 is live, high while a frame byte is on the PHY outputs.
// - Bits 28 to 25 hold the attempt count minus one.
// - Bit 23 marks a collision on each of sixteen attempts.
// - Bit 22 marks a late collision during the frame.
// - Bit 20 marks a deferred frame, bit 21 an overlong deferral.
// - Bit 19 marks a VLAN type field while VLAN transmit is enabled.
// - Bits 18 to 5 hold the frame length, saturating at 16368.
// - Bit 4 marks the MAC control type code 88-08.
// - Bit 3 underrun, bit 2 multicast, bit 1 broadcast, bit 0 sent without error.
package eth_tx_pkg;
  // Register map, one word each.
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_STATS  = 8'h08;
  localparam int unsigned CTRL_HALF   = 0;
  localparam int unsigned CTRL_SPD    = 1;
  localparam int unsigned CTRL_VLAN   = 3;
  localparam int unsigned CTRL_PFC    = 4;
  localparam int unsigned CTRL_IFG    = 5;
  localparam logic [5:0]  CTRL_RESET  = 6'h04;
  localparam logic [1:0]  SPEED_10    = 2'h0;
  localparam logic [1:0]  SPEED_100   = 2'h1;
  localparam logic [1:0]  SPEED_1G    = 2'h2;
  // Byte strobe divider reloads, one less than the period.
  localparam logic [6:0]  DIV_1G_M1   = 7'h00;
  localparam logic [6:0]  DIV_100_M1  = 7'h09;
  localparam logic [6:0]  DIV_10_M1   = 7'h63;
  // Latencies in enabled cycles; the receive synchroniser eats two of them.
  localparam logic [4:0]  TX_LAT_FAST = 5'h08;
  localparam logic [4:0]  TX_LAT_SLOW = 5'h07;
  localparam logic [4:0]  RX_TAP      = 5'h0d;
  localparam int unsigned TX_DEPTH    = 8;
  localparam int unsigned RX_DEPTH    = 16;
  localparam logic [7:0]  MIN_IFG     = 8'h0c;
  localparam logic [13:0] SLOT_BYTES  = 14'h0040;
  localparam logic [13:0] LEN_SAT     = 14'h3ff0;
  localparam logic [5:0]  CTRL_LAST   = 6'h3b;
  localparam logic [47:0] CTRL_DA     = 48'h0180_c200_0001;
  localparam logic [15:0] TYPE_CTRL   = 16'h8808;
  localparam logic [15:0] TYPE_VLAN   = 16'h8100;
  localparam logic [15:0] OPC_PAUSE   = 16'h0001;
  localparam logic [15:0] OPC_PFC     = 16'h0101;
  // Statistics vector bit positions.
  localparam int unsigned SB_PFC      = 32;
  localparam int unsigned SB_PAUSE    = 31;
  localparam int unsigned SB_BYTE     = 30;
  localparam int unsigned SB_RSV_HI   = 29;
  localparam int unsigned SB_ATT_LO   = 25;
  localparam int unsigned SB_RSV_LO   = 24;
  localparam int unsigned SB_EXCOL    = 23;
  localparam int unsigned SB_LATE     = 22;
  localparam int unsigned SB_OVERLONG = 21;
  localparam int unsigned SB_DEFER    = 20;
  localparam int unsigned SB_VLAN     = 19;
  localparam int unsigned SB_LEN_LO   = 5;
  localparam int unsigned SB_CTRL     = 4;
  localparam int unsigned SB_UNDERRUN = 3;
  localparam int unsigned SB_MCAST    = 2;
  localparam int unsigned SB_BCAST    = 1;
  localparam int unsigned SB_OK       = 0;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_GAP  = 5'h02,
    S_SEND = 5'h04,
    S_CTRL = 5'h08,
    S_DROP = 5'h10
  } tx_state_t;

  // One byte slot toward or from the PHY.
  typedef struct packed {
    logic       en;
    logic       er;
    logic [7:0] data;
  } phy_byte_t;

  typedef struct packed {
    tx_state_t   fsm;
    logic [6:0]  div;
    logic [5:0]  ctrl;
    logic        wb_ack;
    logic [31:0] wb_dat;
    logic        col_m;
    logic        col;
    logic        crs_m;
    logic        crs;
    phy_byte_t   rx_m;
    phy_byte_t   rx_s;
    logic [7:0]  gap;
    logic [13:0] cnt;
    logic [3:0]  tries;
    logic [15:0] wait_cnt;
    logic        deferred;
    logic        overlong_wait_bit;
    logic        underrun;
    logic        mcast;
    logic        bcast;
    logic        is_ctrl;
    logic        is_vlan;
    logic [7:0]  type_hi;
    logic        pause_pend;
    logic        pfc_pend;
    logic        ctrl_pfc;
    logic [5:0]  cidx;
    logic [32:0] stats;
    logic        stats_valid;
    logic        collision;
    logic        retransmit;
  } core_state_t;
endpackage

// File: logic/byte_delay_line.sv
// Enabled shift pipeline with a selectable output tap.
module byte_delay_line #(
  parameter int unsigned W     = 10,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic [4:0]   tap,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] pipe;
  } dl_state_t;

  dl_state_t s;
  dl_state_t next_s;

  // Shift only on the byte strobe, so latency counts enabled cycles.
  always_comb begin
    next_s = s;
    if (en) begin
      next_s.pipe = {s.pipe[DEPTH-2:0], din};
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Tap one selects the first stage; every stage is a flip-flop.
  assign dout = s.pipe[tap - 5'h01];
endmodule // byte_delay_line

// File: bench/tx_client_model.sv
// Client transmit stream source that feeds the transmit path.
module tx_client_model (
  input  wire logic       clk,
  input  wire logic       ready,
  input  wire logic       retx,
  output logic      [7:0] tdata,
  output logic            tvalid,
  output logic            tlast,
  output logic            tuser
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] frm[$];
  int         idx = 0;
  logic       bad = 1'b0;
  initial begin
    {tdata, tvalid, tlast, tuser} = '0;
  end
  // A byte is held until it is taken; a resend request restarts at byte 0.
  always @(posedge clk) begin
    if (retx === 1'b1) idx = 0;
    else if (tvalid && ready === 1'b1) idx++;
    if (idx > 0 && idx == frm.size()) begin
      frm = {};
      idx = 0;
    end
    tvalid <= idx < frm.size();
    // Idle data is inverted so a stale byte never looks valid.
    tdata <= idx < frm.size() ? frm[idx] : ~tdata;
    tlast <= idx == frm.size() - 1;
    tuser <= bad && idx == frm.size() - 1;
  end
endmodule // tx_client_model

// File: bench/tb_ethernet_mac_tx_client_path.sv
// Self-checking bench for the transmit client path.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_ethernet_mac_tx_client_path;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, col = 0, rxdv = 0, rxer = 0, crs = 0, preq = 0, fast = 1;
  logic [7:0] adr = 0, rxd = 0, ifg = 0, tdata, txd, rxo, eb;
  logic [9:0] rxq[$], erx;
  logic [31:0] wdat = 0, rd, rdat, last_s;
  logic [32:0] stats;
  logic ack, tvalid, tlast, tuser, tready, col_o, retx, stv, txen, txer, rxv, rxu, chk_phy = 1;
  int seed = 32'h94ad4e24, error_cnt = 0, checks = 0, nstat = 0, ncol = 0, nretx = 0, ner = 0;
  logic [7:0] f[$], exq[$];
  always #5 clk = ~clk;
  eth_tx_client #(.MAX_DEFER_CYCLES(16)) dut (.REF_CLK(clk), .RESETN(rst_n), .WB_CYC(cyc),
    .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK(ack), .TX_TDATA(tdata), .TX_TVALID(tvalid), .TX_TLAST(tlast), .TX_TUSER(tuser),
    .TX_TREADY(tready), .TX_IFG_DELAY(ifg), .TX_COLLISION(col_o), .TX_RETRANSMIT(retx),
    .TX_STATS(stats), .TX_STATS_VALID(stv), .PAUSE_REQ(preq), .PFC_REQ(1'b0), .PHY_TXD(txd),
    .PHY_TX_EN(txen), .PHY_TX_ER(txer), .PHY_COL(col), .PHY_CRS(crs), .PHY_RXD(rxd),
    .PHY_RX_DV(rxdv), .PHY_RX_ER(rxer), .RX_TDATA(rxo), .RX_TVALID(rxv), .RX_TUSER(rxu));
  tx_client_model client (.clk(clk), .ready(tready), .retx(retx), .tdata(tdata),
    .tvalid(tvalid), .tlast(tlast), .tuser(tuser));
  // Reference checks on the PHY byte order and on statistics at each frame end.
  always @(posedge clk) begin
    if (tvalid && tready === 1'b1 && chk_phy) exq.push_back(tdata);
    if (txen === 1'b1 && chk_phy) begin
      eb = exq.pop_front();
      `CHK(txd, eb)
    end
    // Receive reference: pins taken at one edge show on the client side fifteen edges later, at gigabit only.
    if (fast && rst_n) begin
      rxq.push_back({rxer, rxdv, rxd});
      if (rxq.size() > 15) begin
        erx = rxq.pop_front();
        `CHK({rxu, rxv, rxo}, erx)
      end
    end
    if (stv === 1'b1) begin
      nstat++;
      `CHK(stats[31:0] & 32'hbfffffff, last_s)
    end
    ner += (txer === 1'b1);
    ncol += (col_o === 1'b1);
    nretx += (col_o === 1'b1 && retx === 1'b1);
    // One collision is enough; the medium then clears.
    if (col_o === 1'b1) col <= 0;
    rxd <= $random(seed);
    rxdv <= $random(seed);
    rxer <= $random(seed);
    ifg <= $random(seed);
  end
  // Classic cycle: hold until ack is seen, release at that edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic send(input int len, input logic [7:0] da0, input logic user, input int tries);
    int n;
    n = nstat + 1;
    f = {};
    for (int i = 0; i < len; i++) f.push_back(i < 6 ? da0 : 8'($random(seed)));
    if (da0 == 8'h01) {f[12], f[13]} = 16'h8808;
    last_s = 0;
    last_s[28:25] = 4'(tries);
    last_s[18:5] = 14'(len);
    last_s[4] = {f[12], f[13]} == 16'h8808;
    last_s[3:0] = {user, da0[0], da0 == 8'hff, !user};
    client.bad = user;
    client.frm = f;
    wait (nstat == n);
    repeat (20) @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog sized well above the frames and register traffic.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    wb(0, 8'h00, 0, rd);
    `CHK(rd[5:0], eth_tx_pkg::CTRL_RESET)
    col <= 1;
    send(64, 8'hff, 0, 0);
    `CHK(ncol, 0)
    col <= 0;
    $display("test 1 done");
    send(60, 8'h01, 1, 0);
    `CHK(ner > 0, 1'b1)
    wb(0, eth_tx_pkg::ADDR_STATS, 0, rd);
    `CHK(rd, last_s)
    wb(0, 8'h40, 0, rd);
    `CHK(rd, 32'h0)
    $display("test 2 done");
    wb(1, 8'h00, 32'h5, rd);
    chk_phy = 0;
    col <= 1;
    send(70, 8'h02, 0, 1);
    `CHK(nretx, 1)
    `CHK(ncol, 1)
    $display("test 3 done");
    // Half duplex at 100 Mb/s: carrier defers a pause frame past the limit, then a paced client frame.
    fast = 0;
    wb(1, 8'h00, 32'h3, rd);
    {crs, preq} <= 2'b11;
    last_s = {1'b1, 9'h000, 2'b11, 1'b0, 14'(60), 5'h15};
    repeat (40) @(posedge clk);
    {crs, preq} <= 2'b00;
    wait (nstat == 4);
    repeat (20) @(posedge clk);
    send(60, 8'h04, 0, 0);
    $display("test 4 done");
    final_report();
  end
endmodule // tb_ethernet_mac_tx_client_path
